// ===== verilog/cesa_pkg.sv
// Constants shared by the event counter, serial store and alarm logic.
`default_nettype none
package cesa_pkg;
	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [7:0] ADDR_RTC_CTRL  = 8'h00; // Alarm flag, gate, trim mode.
	localparam logic [7:0] ADDR_CNT_CTRL  = 8'h0D; // Event counter control.
	localparam logic [7:0] ADDR_CNT_LO    = 8'h0E; // Count, low byte.
	localparam logic [7:0] ADDR_CNT_HI    = 8'h0F; // Count, high byte.
	localparam logic [7:0] ADDR_SN_FIRST  = 8'h10; // First serial identity byte.
	localparam logic [7:0] ADDR_SN_LAST   = 8'h17; // Last serial identity byte.
	localparam logic [7:0] ADDR_COMP_CTRL = 8'h18; // Companion control.
	localparam logic [7:0] ADDR_ALM_FIRST = 8'h19; // Seconds, minutes, hours, date, month.
	localparam int         ALM_FIELDS     = 5;     // Number of alarm compare fields.

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int RTC_GATE_BIT   = 7; // Alarm match gate.
	localparam int RTC_FLAG_BIT   = 6; // Sticky alarm flag.
	localparam int RTC_TRIM_BIT   = 2; // Trim mode, 512 Hz on the pin.
	localparam int CNT_PERS_BIT   = 7; // Count only on main supply when set.
	localparam int CNT_SNAP_BIT   = 3; // Freeze the readable count.
	localparam int CNT_UNLK_BIT   = 2; // Allow count writes, block edges.
	localparam int CNT_POLL_BIT   = 1; // Sampled tamper mode.
	localparam int CNT_POL_BIT    = 0; // One selects rising edges.
	localparam int COMP_LOCK_BIT  = 7; // One-way serial lock.
	localparam int COMP_SEL_BIT   = 6; // One selects alarm on the pin.
	localparam int COMP_FHI_BIT   = 5; // Wave frequency select, high bit.
	localparam int COMP_FLO_BIT   = 4; // Wave frequency select, low bit.
	localparam int ALM_MATCH_BIT  = 7; // Zero includes the field.

	// ==========================================================
	// Masks and reset values
	// ==========================================================
	localparam logic [7:0] CNT_CTRL_MASK  = 8'h8F; // Implemented control bits.
	localparam logic [7:0] COMP_PLAIN_MSK = 8'h0F; // Stored bits with no local effect.
	localparam logic [7:0] CNT_CTRL_RST   = 8'h00;
	localparam logic [7:0] COMP_CTRL_RST  = 8'h00;
	localparam logic [7:0] ALM_RST        = 8'h80; // Field excluded after reset.

	// ==========================================================
	// Wave frequency codes and divider taps
	// ==========================================================
	localparam logic [1:0] FREQ_1HZ   = 2'h0;
	localparam logic [1:0] FREQ_512HZ = 2'h1;
	localparam logic [1:0] FREQ_4KHZ  = 2'h2;
	localparam logic [1:0] FREQ_32KHZ = 2'h3;
	localparam int         DIV_W      = 15; // Divider of oscillator periods.
	localparam int         TAP_1HZ    = 14;
	localparam int         TAP_512HZ  = 5;
	localparam int         TAP_4KHZ   = 2;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_HZ           = 10_000_000;
	localparam int OSC_HZ           = 32768;
	localparam int POLL_PERIOD_MS   = 125;
	localparam int POLL_TICKS       = OSC_HZ * POLL_PERIOD_MS / 1000;
	localparam int POLL_TICK_W      = $clog2(POLL_TICKS);
	localparam int POLL_PULL_NS     = 2000;
	localparam int POLL_PULL_CYCLES = (POLL_PULL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Tamper sampling sequencer.
	typedef enum logic [1:0] {
		CESA_POLL_IDLE = 2'h1,
		CESA_POLL_PULL = 2'h2
	} cesa_poll_e;
endpackage
`default_nettype wire

// ===== verilog/cesa_id_store.sv
// Small byte store for the serial identity, with registered read data.
`default_nettype none
module cesa_id_store #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     resetn,
	// Write and read side
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] addr,
	input  wire logic [WIDTH-1:0]         wdata,
	output var  logic [WIDTH-1:0]         rdata
);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Stored bytes.
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [WIDTH-1:0] rdata_next;

	// Write decode; the read follows the address every cycle.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (wr_en) begin
			mem_next[addr] = wdata;
		end
		rdata_next = mem_reg[addr];
	end

	// Storage and the read register.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			rdata <= '0;
		end else begin
			mem_reg <= mem_next;
			rdata   <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/cesa_field_match.sv
// One alarm compare field: included fields must equal the current time.
`default_nettype none
module cesa_field_match #(
	parameter int MATCH_BIT = 7
) (
	// Alarm setting and current time
	input  wire logic [7:0] setting,
	input  wire logic [7:0] now,
	// Result
	output var  logic       hit
);
	// A set match bit excludes the field, so it always counts as a hit.
	always_comb begin
		hit = setting[MATCH_BIT] || (setting[MATCH_BIT-1:0] == now[MATCH_BIT-1:0]);
	end
endmodule
`default_nettype wire

// ===== verilog/cesa_top.sv
// Companion event counter, serial identity store and calendar alarm.
`default_nettype none
module cesa_top #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Companion register access
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output var  logic [7:0] reg_rdata,
	output var  logic       reg_rvalid,
	// Event switch
	input  wire logic       event_input,
	output var  logic       event_pull_en,
	// Supply state
	input  wire logic       main_supply_ok,
	// Oscillator and current time
	input  wire logic       osc_level,
	input  wire logic       osc_running,
	input  wire logic       time_update,
	input  wire logic [7:0] now_sec,
	input  wire logic [7:0] now_min,
	input  wire logic [7:0] now_hour,
	input  wire logic [7:0] now_date,
	input  wire logic [7:0] now_month,
	// Shared alarm and wave pin
	output var  logic       alarm_wave_out,
	output var  logic       alarm_wave_oe_n
);
	// ==========================================================
	// Declarations
	// ==========================================================
	localparam logic [CNT_W-1:0] CNT_MAX = '1;          // Saturation value.
	localparam logic [5:0] PULL_LAST = 6'(cesa_pkg::POLL_PULL_CYCLES - 1);

	logic [7:0]       cnt_ctrl_reg, cnt_ctrl_next;      // Counter control.
	logic [CNT_W-1:0] cnt_reg, cnt_next;                // Live count.
	logic [CNT_W-1:0] snap_reg, snap_next;              // Frozen count.
	logic             prev_reg, prev_next;              // Previous input level.
	logic [7:0]       comp_reg, comp_next;              // Companion control.
	logic             aen_reg, aen_next;                // Alarm match gate.
	logic             flag_reg, flag_next;              // Sticky alarm flag.
	logic             trim_reg, trim_next;              // Trim mode.
	logic [7:0]       alm_reg [cesa_pkg::ALM_FIELDS];   // Alarm compare fields.
	logic [7:0]       alm_next [cesa_pkg::ALM_FIELDS];
	logic [7:0]       now_fields [cesa_pkg::ALM_FIELDS];
	logic [cesa_pkg::ALM_FIELDS-1:0] hits;              // Per-field results.
	logic             osc_q_reg;                        // Registered oscillator.
	logic [cesa_pkg::DIV_W-1:0] div_reg, div_next;      // Oscillator divider.
	cesa_pkg::cesa_poll_e poll_reg, poll_next;          // Tamper sequencer.
	logic [5:0]       pull_cnt_reg, pull_cnt_next;      // Pull length counter.
	logic             poll_lvl_reg, poll_lvl_next;      // Last sampled level.
	logic             pull_next;
	logic             rd_q_reg;                         // Read in flight.
	logic [7:0]       addr_q_reg;                       // Address of that read.
	logic [7:0]       rdata_next;
	logic             pin_next, oe_n_next;
	logic [7:0]       sn_rdata;                         // Serial store output.
	logic             osc_rise, poll_tick, level, edge_seen, count_ok, match;
	logic             wr_cnt_lo, wr_cnt_hi, sn_hit, wave;

	assign now_fields = '{now_sec, now_min, now_hour, now_date, now_month};

	// ==========================================================
	// Serial identity store and alarm field comparators
	// ==========================================================
	// Serial bytes live behind the same register access as the rest.
	assign sn_hit = (reg_addr >= cesa_pkg::ADDR_SN_FIRST)
		&& (reg_addr <= cesa_pkg::ADDR_SN_LAST);

	cesa_id_store #(.DEPTH(8), .WIDTH(8)) u_id_store (
		.clock  (clock),
		.resetn (resetn),
		.wr_en  (reg_write && sn_hit && !comp_reg[cesa_pkg::COMP_LOCK_BIT]),
		.addr   (reg_addr[2:0]),
		.wdata  (reg_wdata),
		.rdata  (sn_rdata)
	);

	// Each field is compared literally, whatever the combination.
	for (genvar g = 0; g < cesa_pkg::ALM_FIELDS; g++) begin : g_field
		cesa_field_match #(.MATCH_BIT(cesa_pkg::ALM_MATCH_BIT)) u_match (
			.setting (alm_reg[g]),
			.now     (now_fields[g]),
			.hit     (hits[g])
		);
	end

	// ==========================================================
	// Oscillator divider and tamper sampling
	// ==========================================================
	// The divider counts oscillator periods only while the oscillator runs,
	// so the sampling interval stops with it.
	always_comb begin
		osc_rise  = osc_level && !osc_q_reg;
		div_next  = div_reg;
		if (osc_rise && osc_running) begin
			div_next = div_reg + 1'b1;
		end
		poll_tick = osc_rise && osc_running
			&& (&div_reg[cesa_pkg::POLL_TICK_W-1:0]);
		poll_next     = poll_reg;
		pull_cnt_next = pull_cnt_reg;
		poll_lvl_next = poll_lvl_reg;
		case (poll_reg)
			cesa_pkg::CESA_POLL_IDLE: begin
				// Start a short pull-up once per interval in tamper mode.
				if (cnt_ctrl_reg[cesa_pkg::CNT_POLL_BIT] && poll_tick) begin
					poll_next     = cesa_pkg::CESA_POLL_PULL;
					pull_cnt_next = PULL_LAST;
				end
			end
			cesa_pkg::CESA_POLL_PULL: begin
				// Sample in the last pulled cycle, while the pin has settled.
				if (pull_cnt_reg == 6'h00) begin
					poll_next     = cesa_pkg::CESA_POLL_IDLE;
					poll_lvl_next = event_input;
				end else begin
					pull_cnt_next = pull_cnt_reg - 1'b1;
				end
			end
			default: begin
				poll_next = cesa_pkg::CESA_POLL_IDLE;
			end
		endcase
		pull_next = (poll_next == cesa_pkg::CESA_POLL_PULL);
	end

	// ==========================================================
	// Event counter
	// ==========================================================
	// In tamper mode the edge detector watches the sampled level instead of
	// the pin, so an opened switch looks like a rising edge.
	always_comb begin
		wr_cnt_lo = reg_write && (reg_addr == cesa_pkg::ADDR_CNT_LO);
		wr_cnt_hi = reg_write && (reg_addr == cesa_pkg::ADDR_CNT_HI);
		level = cnt_ctrl_reg[cesa_pkg::CNT_POLL_BIT] ? poll_lvl_reg : event_input;
		prev_next = level;
		if (cnt_ctrl_reg[cesa_pkg::CNT_POL_BIT]) begin
			edge_seen = level && !prev_reg;
		end else begin
			edge_seen = !level && prev_reg;
		end
		// Backup-powered counting is allowed whenever the persist bit is low.
		count_ok = !cnt_ctrl_reg[cesa_pkg::CNT_UNLK_BIT]
			&& (!cnt_ctrl_reg[cesa_pkg::CNT_PERS_BIT] || main_supply_ok)
			&& (cnt_reg != CNT_MAX);
		cnt_next = cnt_reg;
		if (cnt_ctrl_reg[cesa_pkg::CNT_UNLK_BIT] && (wr_cnt_lo || wr_cnt_hi)) begin
			if (wr_cnt_lo) begin
				cnt_next[7:0] = reg_wdata;
			end
			if (wr_cnt_hi) begin
				cnt_next[CNT_W-1:8] = reg_wdata[CNT_W-9:0];
			end
		end else if (edge_seen && count_ok) begin
			cnt_next = cnt_reg + 1'b1;
		end
		cnt_ctrl_next = cnt_ctrl_reg;
		if (reg_write && (reg_addr == cesa_pkg::ADDR_CNT_CTRL)) begin
			cnt_ctrl_next = reg_wdata & cesa_pkg::CNT_CTRL_MASK;
		end
		// Capture on the rising snapshot bit and hold until it drops.
		snap_next = snap_reg;
		if (cnt_ctrl_next[cesa_pkg::CNT_SNAP_BIT]
				&& !cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT]) begin
			snap_next = cnt_reg;
		end
	end

	// ==========================================================
	// Companion control and alarm
	// ==========================================================
	// The lock only ever sets; the alarm flag is set by a gated match and
	// cleared by writing zero, with the set winning a same-cycle clash.
	always_comb begin
		comp_next = comp_reg;
		aen_next  = aen_reg;
		trim_next = trim_reg;
		for (int i = 0; i < cesa_pkg::ALM_FIELDS; i++) begin
			alm_next[i] = alm_reg[i];
			if (reg_write && (reg_addr == cesa_pkg::ADDR_ALM_FIRST + 8'(i))) begin
				alm_next[i] = reg_wdata;
			end
		end
		if (reg_write && (reg_addr == cesa_pkg::ADDR_COMP_CTRL)) begin
			comp_next = reg_wdata & cesa_pkg::COMP_PLAIN_MSK;
			comp_next[cesa_pkg::COMP_SEL_BIT] = reg_wdata[cesa_pkg::COMP_SEL_BIT];
			comp_next[cesa_pkg::COMP_FHI_BIT] = reg_wdata[cesa_pkg::COMP_FHI_BIT];
			comp_next[cesa_pkg::COMP_FLO_BIT] = reg_wdata[cesa_pkg::COMP_FLO_BIT];
			comp_next[cesa_pkg::COMP_LOCK_BIT] = comp_reg[cesa_pkg::COMP_LOCK_BIT]
				|| reg_wdata[cesa_pkg::COMP_LOCK_BIT];
		end
		// The comparator runs whatever the pin shows, trim mode included.
		match = time_update && (&hits);
		flag_next = flag_reg;
		if (reg_write && (reg_addr == cesa_pkg::ADDR_RTC_CTRL)) begin
			aen_next  = reg_wdata[cesa_pkg::RTC_GATE_BIT];
			trim_next = reg_wdata[cesa_pkg::RTC_TRIM_BIT];
			if (!reg_wdata[cesa_pkg::RTC_FLAG_BIT]) begin
				flag_next = 1'b0;
			end
		end
		if (match && aen_reg) begin
			flag_next = 1'b1;
		end
	end

	// ==========================================================
	// Shared pin and read data
	// ==========================================================
	// The enable is active low; the alarm drives the pin low while flagged with the gate set, and floats it with the gate clear.
	always_comb begin
		case (comp_reg[cesa_pkg::COMP_FHI_BIT:cesa_pkg::COMP_FLO_BIT])
			cesa_pkg::FREQ_1HZ:   wave = div_reg[cesa_pkg::TAP_1HZ];
			cesa_pkg::FREQ_512HZ: wave = div_reg[cesa_pkg::TAP_512HZ];
			cesa_pkg::FREQ_4KHZ:  wave = div_reg[cesa_pkg::TAP_4KHZ];
			default:              wave = osc_q_reg;
		endcase
		pin_next  = 1'b1;
		oe_n_next = 1'b0;
		if (trim_reg) begin
			pin_next = div_reg[cesa_pkg::TAP_512HZ];
		end else if (!comp_reg[cesa_pkg::COMP_SEL_BIT]) begin
			pin_next = wave;
		end else if (aen_reg) begin
			pin_next = !flag_reg;
		end else begin
			oe_n_next = 1'b1;
		end
		// Reads use the address taken one cycle earlier, in step with the store.
		rdata_next = 8'h00;
		if ((addr_q_reg >= cesa_pkg::ADDR_SN_FIRST)
				&& (addr_q_reg <= cesa_pkg::ADDR_SN_LAST)) begin
			rdata_next = sn_rdata;
		end else if ((addr_q_reg >= cesa_pkg::ADDR_ALM_FIRST) && (addr_q_reg
				< cesa_pkg::ADDR_ALM_FIRST + 8'(cesa_pkg::ALM_FIELDS))) begin
			rdata_next = alm_reg[3'(addr_q_reg - cesa_pkg::ADDR_ALM_FIRST)];
		end else begin
			case (addr_q_reg)
				cesa_pkg::ADDR_RTC_CTRL: begin
					rdata_next[cesa_pkg::RTC_GATE_BIT] = aen_reg;
					rdata_next[cesa_pkg::RTC_FLAG_BIT] = flag_reg;
					rdata_next[cesa_pkg::RTC_TRIM_BIT] = trim_reg;
				end
				cesa_pkg::ADDR_CNT_CTRL:  rdata_next = cnt_ctrl_reg;
				cesa_pkg::ADDR_CNT_LO:    rdata_next = cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT]
					? snap_reg[7:0] : cnt_reg[7:0];
				cesa_pkg::ADDR_CNT_HI:    rdata_next = cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT]
					? snap_reg[15:8] : cnt_reg[15:8];
				cesa_pkg::ADDR_COMP_CTRL: rdata_next = comp_reg;
				default:                  rdata_next = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// State registers
	// ==========================================================
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_ctrl_reg    <= cesa_pkg::CNT_CTRL_RST;
			cnt_reg         <= '0;
			snap_reg        <= '0;
			prev_reg        <= 1'b0;
			comp_reg        <= cesa_pkg::COMP_CTRL_RST;
			aen_reg         <= 1'b0;
			flag_reg        <= 1'b0;
			trim_reg        <= 1'b0;
			for (int i = 0; i < cesa_pkg::ALM_FIELDS; i++) begin
				alm_reg[i] <= cesa_pkg::ALM_RST;
			end
			osc_q_reg       <= 1'b0;
			div_reg         <= '0;
			poll_reg        <= cesa_pkg::CESA_POLL_IDLE;
			pull_cnt_reg    <= 6'h00;
			poll_lvl_reg    <= 1'b0;
			event_pull_en   <= 1'b0;
			rd_q_reg        <= 1'b0;
			addr_q_reg      <= 8'h00;
			reg_rdata       <= 8'h00;
			reg_rvalid      <= 1'b0;
			alarm_wave_out  <= 1'b1;
			alarm_wave_oe_n <= 1'b1;
		end else begin
			cnt_ctrl_reg    <= cnt_ctrl_next;
			cnt_reg         <= cnt_next;
			snap_reg        <= snap_next;
			prev_reg        <= prev_next;
			comp_reg        <= comp_next;
			aen_reg         <= aen_next;
			flag_reg        <= flag_next;
			trim_reg        <= trim_next;
			alm_reg         <= alm_next;
			osc_q_reg       <= osc_level;
			div_reg         <= div_next;
			poll_reg        <= poll_next;
			pull_cnt_reg    <= pull_cnt_next;
			poll_lvl_reg    <= poll_lvl_next;
			event_pull_en   <= pull_next;
			rd_q_reg        <= reg_read;
			addr_q_reg      <= reg_addr;
			reg_rdata       <= rd_q_reg ? rdata_next : reg_rdata;
			reg_rvalid      <= rd_q_reg;
			alarm_wave_out  <= pin_next;
			alarm_wave_oe_n <= oe_n_next;
		end
	end

	// ==========================================================
	// Assertions and covers
	// ==========================================================
	localparam int A_PULL_LAST = cesa_pkg::POLL_PULL_CYCLES - 1;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_count_step: assert property (!(wr_cnt_lo || wr_cnt_hi) |=>
		(cnt_reg == $past(cnt_reg)) || (cnt_reg == $past(cnt_reg) + 1'b1))
		else $error("count moved by more than one");
	a_unlock_blocks: assert property (
		(cnt_ctrl_reg[cesa_pkg::CNT_UNLK_BIT] && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(cnt_reg))
		else $error("count changed while unlocked");
	a_sat_holds: assert property (
		(cnt_reg == CNT_MAX && !wr_cnt_lo && !wr_cnt_hi) |=> (cnt_reg == CNT_MAX))
		else $error("count left the top value");
	a_snap_frozen: assert property (
		(cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT] && $past(cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT]))
		|-> $stable(snap_reg)) else $error("snapshot changed while frozen");
	a_lock_sticky: assert property (comp_reg[cesa_pkg::COMP_LOCK_BIT]
		|=> comp_reg[cesa_pkg::COMP_LOCK_BIT]) else $error("serial lock cleared");
	a_flag_gated: assert property ((!flag_reg && !aen_reg) |=> !flag_reg)
		else $error("flag set with gate clear");
	a_flag_holds: assert property ((flag_reg && !(reg_write
		&& reg_addr == cesa_pkg::ADDR_RTC_CTRL && !reg_wdata[cesa_pkg::RTC_FLAG_BIT]))
		|=> flag_reg) else $error("flag dropped without a clear");
	a_flag_sets: assert property ((match && aen_reg) |=> flag_reg)
		else $error("gated match did not set flag");
	a_trim_pin: assert property (trim_reg |=> (!alarm_wave_oe_n
		&& alarm_wave_out == $past(div_reg[cesa_pkg::TAP_512HZ])))
		else $error("trim mode not on the pin");
	a_pin_float: assert property ((!trim_reg && comp_reg[cesa_pkg::COMP_SEL_BIT]
		&& !aen_reg) |=> alarm_wave_oe_n) else $error("pin driven while floating");
	a_pull_width: assert property ($rose(event_pull_en)
		|-> ##A_PULL_LAST event_pull_en ##1 !event_pull_en)
		else $error("pull-up pulse has the wrong width");

	c_saturate: cover property (cnt_reg == CNT_MAX);
	c_flag_set: cover property ($rose(flag_reg));
	c_poll_pull: cover property ($rose(event_pull_en));
	c_snapshot: cover property ($rose(cnt_ctrl_reg[cesa_pkg::CNT_SNAP_BIT]));
endmodule
`default_nettype wire

// ===== verif/cesa_switch.sv
// Event switch model standing at the far side of the event input.
`default_nettype none
module cesa_switch (
	// Switch contact (one is open), device pull and board pull-up
	input  wire logic level,
	input  wire logic pull_en,
	input  wire logic ext_pull,
	// Pin seen by the device
	output var  logic event_input
);
	timeunit 1ns;
	timeprecision 1ns;
	// A closed contact grounds the pin even against the device pull.
	// An open pin with no pull at all floats, and is shown low here.
	assign event_input = level && (pull_en || ext_pull);
endmodule
`default_nettype wire

// ===== verif/tb_cesa_top.sv
// Self-checking bench for the companion counter, serial store and alarm.
`default_nettype none
module tb_cesa_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 0, resetn = 0, wr = 0, rd = 0, lvl = 0, tu = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, t = 8'h00, rdata;
	logic       rvalid, pull, ev, aw, aw_oe_n;
	logic       ms = 1, xp = 1, osc = 0, osr = 0;
	int         mismatches = 0, n_compared = 0;
	cesa_switch sw_u (.level(lvl), .pull_en(pull), .ext_pull(xp), .event_input(ev));
	cesa_top dut_u (.clock(clock), .resetn(resetn), .reg_addr(addr), .reg_wdata(wd),
		.reg_write(wr), .reg_read(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.event_input(ev), .event_pull_en(pull), .main_supply_ok(ms),
		.osc_level(osc), .osc_running(osr), .time_update(tu), .now_sec(t),
		.now_min(t), .now_hour(t), .now_date(t), .now_month(t),
		.alarm_wave_out(aw), .alarm_wave_oe_n(aw_oe_n));
	// One comparison, counted; a mismatch is reported at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 addr = a;
		wd = d;
		wr = 1;
		@(posedge clock);
		#1 wr = 0;
	endtask
	// The answer stands for one cycle after the edge that follows the strobe edge.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1 addr = a;
		rd = 1;
		@(posedge clock);
		#1 rd = 0;
		@(posedge clock);
		#1 chk(rvalid === 1'b1 ? rdata : ~exp, exp);
	endtask
	// Move the switch level and let the count settle.
	task automatic edge_to(input logic v);
		@(posedge clock);
		#1 lvl = v;
		repeat (2) @(posedge clock);
	endtask
	// Raise the new-second pulse for one cycle.
	task automatic tick_sec;
		@(posedge clock);
		#1 tu = 1;
		@(posedge clock);
		#1 tu = 0;
	endtask
	// Wait at most a little over one sampling interval for a pull-up pulse.
	task automatic wait_pull(output int k);
		k = 0;
		while (pull !== 1'b1 && k < 9000) begin
			@(posedge clock);
			#1 k++;
		end
	endtask
	// Count pin changes over 32 oscillator periods: two per wave period.
	task automatic wave_chk(input logic [1:0] code, input logic [7:0] exp);
		logic last;
		int   n = 0;
		wr_reg(8'h18, {2'b10, code, 4'h0});
		repeat (4) @(posedge clock);
		#1 last = aw;
		repeat (64) begin
			@(posedge clock);
			#1 if (aw !== last) n++;
			last = aw;
		end
		chk(8'(n), exp);
	endtask
	task automatic test_count;
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(8'h0E, 8'h01);
		wr_reg(8'h0D, 8'h01);
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(8'h0E, 8'h02);
		wr_reg(8'h0D, 8'h09);
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(8'h0E, 8'h02);
		wr_reg(8'h0D, 8'h01);
		rd_chk(8'h0E, 8'h03);
		wr_reg(8'h0D, 8'h81);
		ms = 0;
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(8'h0E, 8'h03);
		wr_reg(8'h0D, 8'h01);
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(8'h0E, 8'h04);
		ms = 1;
		wr_reg(8'h0D, 8'h05);
		wr_reg(8'h0E, 8'hFE);
		wr_reg(8'h0F, 8'hFF);
		edge_to(1'b1);
		rd_chk(8'h0E, 8'hFE);
		wr_reg(8'h0D, 8'h01);
		repeat (2) begin
			edge_to(1'b0);
			edge_to(1'b1);
		end
		rd_chk(8'h0E, 8'hFF);
		rd_chk(8'h0F, 8'hFF);
		$display("count test done");
	endtask
	task automatic test_serial;
		wr_reg(8'h17, 8'hA5);
		wr_reg(8'h18, 8'h80);
		wr_reg(8'h17, 8'h3C);
		wr_reg(8'h18, 8'h00);
		rd_chk(8'h17, 8'hA5);
		rd_chk(8'h18, 8'h80);
		$display("serial test done");
	endtask
	task automatic test_alarm;
		wr_reg(8'h19, 8'h05);
		wr_reg(8'h00, 8'h80);
		wr_reg(8'h18, 8'hC0);
		t = 8'h05;
		tick_sec();
		rd_chk(8'h00, 8'hC0);
		chk({7'h00, aw}, 8'h00);
		wr_reg(8'h00, 8'h40);
		rd_chk(8'h00, 8'h40);
		wr_reg(8'h00, 8'h00);
		tick_sec();
		rd_chk(8'h00, 8'h00);
		chk({7'h00, aw_oe_n}, 8'h01);
		wr_reg(8'h1A, 8'h07);
		wr_reg(8'h00, 8'h84);
		tick_sec();
		t = 8'h07;
		tick_sec();
		rd_chk(8'h00, 8'h84);
		chk({7'h00, aw_oe_n}, 8'h00);
		wr_reg(8'h19, 8'h80);
		tick_sec();
		rd_chk(8'h00, 8'hC4);
		wr_reg(8'h00, 8'h00);
		$display("alarm test done");
	endtask
	task automatic test_tamper;
		int k;
		wr_reg(8'h0D, 8'h04);
		lvl = 0;
		xp = 0;
		wr_reg(8'h0E, 8'h00);
		wr_reg(8'h0F, 8'h00);
		wr_reg(8'h0D, 8'h03);
		wait_pull(k);
		chk({7'h00, pull}, 8'h00);
		osr = 1;
		wait_pull(k);
		chk({7'h00, pull}, 8'h01);
		repeat (24) @(posedge clock);
		rd_chk(8'h0E, 8'h00);
		lvl = 1;
		wait_pull(k);
		chk({7'h00, pull}, 8'h01);
		repeat (24) @(posedge clock);
		rd_chk(8'h0E, 8'h01);
		$display("tamper test done");
	endtask
	task automatic test_wave;
		wave_chk(2'h3, 8'h40);
		wave_chk(2'h2, 8'h08);
		$display("wave test done");
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		forever #50 clock = ~clock;
	end
	// Stand-in oscillator, one level change per clock cycle; the running
	// flag decides whether the design may count it.
	initial begin
		forever begin
			@(posedge clock);
			#1 osc = ~osc;
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		#1 resetn = 1;
		test_count();
		test_serial();
		test_alarm();
		test_tamper();
		test_wave();
		complete_run();
	end
	// The tamper test needs some 26,000 cycles; this allows about 40,000.
	initial begin
		#4000000;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
